// File: ddtp_top.v
// timing-parameter set two of the sdram controller, with apb registers
// assumes scheduler, refresh timer and power requests share clk_i
//
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/100ps
`include "ddtp_defines.vh"

// Functional notes
// - close open bank after programmed+1 refresh intervals
// - power-down exit: non-read waits programmed+1 cycles
// - termination lead field stored, no pin driven
// - self-refresh exit: non-read waits programmed+1 cycles
// - self-refresh exit: read waits programmed+1 cycles
// - read to precharge spacing programmed+1 cycles
// - clock-enable level held programmed+1 cycles minimum
// - config two applies only with bank position set
// - config two write starts sdram initialization
// - timing two writable only while unlock set
// - row width code n means n+9 bits
module ddtp_top (
  input  wire        clk_i,
  input  wire        rstn_i,
  // apb slave
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [11:0] paddr_i,
  input  wire [31:0] pwdata_i,
  output wire [31:0] prdata_o,
  output wire        pready_o,
  output wire        pslverr_o,
  // command request from the scheduler
  input  wire        cmd_valid_i,
  input  wire [2:0]  cmd_code_i,
  input  wire [2:0]  cmd_bank_i,
  output wire        cmd_ready_o,
  // issued command toward the sdram phy
  output wire        cmd_issue_o,
  output wire [2:0]  cmd_code_o,
  output wire [2:0]  cmd_bank_o,
  // low-power requests and clock enable
  input  wire        pd_req_i,
  input  wire        sr_req_i,
  output wire        mem_cke_o,
  // refresh interval tick from the refresh timer
  input  wire        refresh_tick_i,
  output wire [7:0]  force_pre_o,
  // addressing and init control
  output wire [2:0]  partial_refresh_select_o,
  output wire [4:0]  row_addr_bits_o,
  output wire        init_start_o
);

  // power states, one-hot
  localparam ST_ACTIVE = 3'b001;
  localparam ST_PDOWN  = 3'b010;
  localparam ST_SREF   = 3'b100;

  // address match, shared by read and write decode
  function match;
    input [11:0] addr;
    input [11:0] off;
    begin
      match = (addr[11:2] == off[11:2]);
    end
  endfunction

  // ---------------- register storage ----------------
  reg [31:0] main_config_reg;       // unlock and bank position bits
  reg [31:0] timing_params_two_reg; // second timing set
  reg [31:0] config_reg_two_reg;    // partial refresh and row width
  reg [31:0] prdata_reg;            // read data, captured in setup phase
  reg        init_start_reg;        // one-cycle init request

  wire wr_en  = psel_i && penable_i && pwrite_i;
  wire sel_mn = match(paddr_i, `DDTP_OFF_MAIN_CFG);
  wire sel_t2 = match(paddr_i, `DDTP_OFF_TIMING_TWO);
  wire sel_c2 = match(paddr_i, `DDTP_OFF_CFG_TWO);
  wire sel_st = match(paddr_i, `DDTP_OFF_STATUS);
  wire mapped = sel_mn || sel_t2 || sel_c2 || sel_st;

  wire timing_write_unlock  = main_config_reg[`DDTP_MAIN_UNLOCK_BIT];
  wire bank_position_select = main_config_reg[`DDTP_MAIN_BANKPOS_BIT];

  // timing fields
  wire [3:0] max_open_row_intervals = timing_params_two_reg[`DDTP_T2_RASMAX_HI:`DDTP_T2_RASMAX_LO];
  wire [1:0] pd_exit_delay          = timing_params_two_reg[`DDTP_T2_XP_HI:`DDTP_T2_XP_LO];
  wire [6:0] sr_nonread_delay       = timing_params_two_reg[`DDTP_T2_XSNR_HI:`DDTP_T2_XSNR_LO];
  wire [7:0] sr_read_delay          = timing_params_two_reg[`DDTP_T2_XSRD_HI:`DDTP_T2_XSRD_LO];
  wire [2:0] read_to_pre_delay      = timing_params_two_reg[`DDTP_T2_RTP_HI:`DDTP_T2_RTP_LO];
  wire [4:0] cke_min_hold           = timing_params_two_reg[`DDTP_T2_CKE_HI:`DDTP_T2_CKE_LO];

  // ---------------- apb write path ----------------
  // zero-wait slave; writes land at the access edge
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      main_config_reg       <= `DDTP_MAIN_RESET;
      timing_params_two_reg <= `DDTP_T2_RESET;
      config_reg_two_reg    <= `DDTP_C2_RESET;
      init_start_reg        <= 1'b0;
    end else begin
      init_start_reg <= 1'b0;
      if (wr_en && sel_mn) begin
        main_config_reg <= {30'h00000000, pwdata_i[1:0]};
      end
      // locked writes are dropped without error
      if (wr_en && sel_t2 && timing_write_unlock) begin
        // reserved top bit is masked to zero; unused termination timing kept only as stored bits
        timing_params_two_reg <= pwdata_i & `DDTP_T2_WMASK;
      end
      if (wr_en && sel_c2) begin
        config_reg_two_reg <= pwdata_i & `DDTP_C2_WMASK;
        init_start_reg     <= 1'b1;
      end
    end
  end

  // ---------------- apb read path ----------------
  reg [2:0]  pstate_reg;   // power state
  reg        cke_reg;      // memory clock enable
  wire [7:0] open_banks;   // banks holding a row

  // data captured in the setup cycle so it is a flop in access
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      prdata_reg <= 32'h00000000;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      if (sel_mn) begin
        prdata_reg <= main_config_reg;
      end else if (sel_t2) begin
        prdata_reg <= timing_params_two_reg;
      end else if (sel_c2) begin
        prdata_reg <= config_reg_two_reg;
      end else if (sel_st) begin
        prdata_reg <= {8'h00, force_pre_o, open_banks, 4'h0, pstate_reg, cke_reg};
      end else begin
        prdata_reg <= 32'h00000000;
      end
    end
  end

  assign prdata_o  = prdata_reg;
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i && penable_i && !mapped;

  // ---------------- addressing outputs ----------------
  // without special addressing the defaults stand
  assign partial_refresh_select_o = bank_position_select ?
    config_reg_two_reg[`DDTP_C2_PARTIAL_REFRESH_SELECT_HI:`DDTP_C2_PARTIAL_REFRESH_SELECT_LO] : 3'h0;
  assign row_addr_bits_o = bank_position_select ?
    ({2'b00, config_reg_two_reg[`DDTP_C2_ROW_HI:`DDTP_C2_ROW_LO]} + `DDTP_ROW_BITS_BASE)
    : `DDTP_ROW_BITS_DEFAULT;
  assign init_start_o = init_start_reg;

  // ---------------- clock enable and power states ----------------
  wire cke_ok;      // clock enable may change
  wire pd_ok;       // power-down exit gap over
  wire sr_nr_ok;    // self-refresh exit gap for non-reads over
  wire sr_rd_ok;    // self-refresh exit gap for reads over
  wire rtp_ok;      // read-to-precharge gap over
  wire want_low = pd_req_i || sr_req_i;
  reg  cke_fall;    // this cycle drops clock enable
  reg  cke_rise;    // this cycle raises clock enable
  reg  [2:0] pstate_next;

  // entry and exit wait on the hold timer so no cke level is short
  always @* begin
    cke_fall    = 1'b0;
    cke_rise    = 1'b0;
    pstate_next = pstate_reg;
    case (pstate_reg)
      ST_ACTIVE: begin
        if (want_low && cke_ok && !cmd_valid_i) begin
          cke_fall    = 1'b1;
          pstate_next = sr_req_i ? ST_SREF : ST_PDOWN;
        end
      end
      ST_PDOWN, ST_SREF: begin
        if (!want_low && cke_ok) begin
          cke_rise    = 1'b1;
          pstate_next = ST_ACTIVE;
        end
      end
      default: begin
        pstate_next = ST_ACTIVE;
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (!rstn_i) begin
      pstate_reg <= ST_ACTIVE;
      cke_reg    <= 1'b1;
    end else begin
      pstate_reg <= pstate_next;
      if (cke_fall) begin
        cke_reg <= 1'b0;
      end else if (cke_rise) begin
        cke_reg <= 1'b1;
      end
    end
  end

  assign mem_cke_o = cke_reg;

  wire pd_exit = cke_rise && pstate_reg[1];
  wire sr_exit = cke_rise && pstate_reg[2];

  // ---------------- command gating ----------------
  wire is_read = (cmd_code_i == `DDTP_CMD_READ);
  wire is_pre  = (cmd_code_i == `DDTP_CMD_PRECHARGE);
  wire is_act  = (cmd_code_i == `DDTP_CMD_ACTIVATE);

  // reads skip the power-down and non-read gaps, others wait for them
  assign cmd_ready_o = pstate_reg[0] && !cke_fall &&
                       (is_read ? sr_rd_ok
                                : (pd_ok && sr_nr_ok && (!is_pre || rtp_ok)));
  wire cmd_fire = cmd_valid_i && cmd_ready_o;

  // issued command registered toward the phy
  reg       issue_reg;
  reg [2:0] code_reg;
  reg [2:0] bank_reg;
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      issue_reg <= 1'b0;
      code_reg  <= `DDTP_CMD_NOP;
      bank_reg  <= 3'h0;
    end else begin
      issue_reg <= cmd_fire;
      code_reg  <= cmd_fire ? cmd_code_i : `DDTP_CMD_NOP;
      bank_reg  <= cmd_fire ? cmd_bank_i : bank_reg;
    end
  end

  assign cmd_issue_o = issue_reg;
  assign cmd_code_o  = code_reg;
  assign cmd_bank_o  = bank_reg;

  // ---------------- spacing timers ----------------
  // each gap reloads on its trigger event; both self-refresh gaps share sr_exit
  ddtp_gap_timer u_pd_exit (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .start_i (pd_exit),
    .value_i ({6'h00, pd_exit_delay}),
    .ok_o    (pd_ok)
  );

  ddtp_gap_timer u_sr_nonread (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .start_i (sr_exit),
    .value_i ({1'b0, sr_nonread_delay}),
    .ok_o    (sr_nr_ok)
  );

  ddtp_gap_timer u_sr_read (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .start_i (sr_exit),
    .value_i (sr_read_delay),
    .ok_o    (sr_rd_ok)
  );

  // last read restarts the precharge gap
  ddtp_gap_timer u_read_pre (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .start_i (cmd_fire && is_read),
    .value_i ({5'h00, read_to_pre_delay}),
    .ok_o    (rtp_ok)
  );

  // any cke edge restarts the minimum level time
  ddtp_gap_timer u_cke_hold (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .start_i (cke_fall || cke_rise),
    .value_i ({3'h0, cke_min_hold}),
    .ok_o    (cke_ok)
  );

  // ---------------- open-row limit ----------------
  wire [7:0] bank_onehot = 8'h01 << cmd_bank_i;
  wire [7:0] act_vec = (cmd_fire && is_act) ? bank_onehot : 8'h00;
  wire [7:0] pre_vec = (cmd_fire && is_pre) ? bank_onehot : 8'h00;

  // scheduler must precharge any bank flagged here
  ddtp_row_guard u_row_guard (
    .clk_i                    (clk_i),
    .rstn_i                   (rstn_i),
    .act_i                    (act_vec),
    .pre_i                    (pre_vec),
    .refresh_tick_i           (refresh_tick_i),
    .max_open_row_intervals_i (max_open_row_intervals),
    .open_o                   (open_banks),
    .force_pre_o              (force_pre_o)
  );

endmodule

// File: ddtp_defines.vh
// constants for the second timing-parameter set of the sdram controller
// assumes a 10 mhz memory clock and a 32-bit apb register port
`ifndef DDTP_DEFINES_VH
`define DDTP_DEFINES_VH

// register byte offsets on apb
`define DDTP_OFF_MAIN_CFG     12'h000
`define DDTP_OFF_TIMING_TWO   12'h004
`define DDTP_OFF_CFG_TWO      12'h008
`define DDTP_OFF_STATUS       12'h00c

// main_config_reg fields
`define DDTP_MAIN_UNLOCK_BIT  0
`define DDTP_MAIN_BANKPOS_BIT 1
`define DDTP_MAIN_RESET       32'h00000000

// timing_params_two fields
`define DDTP_T2_RSVD_BIT      31
`define DDTP_T2_RASMAX_HI     30
`define DDTP_T2_RASMAX_LO     27
`define DDTP_T2_XP_HI         26
`define DDTP_T2_XP_LO         25
`define DDTP_T2_TERM_HI       24
`define DDTP_T2_TERM_LO       23
`define DDTP_T2_XSNR_HI       22
`define DDTP_T2_XSNR_LO       16
`define DDTP_T2_XSRD_HI       15
`define DDTP_T2_XSRD_LO       8
`define DDTP_T2_RTP_HI        7
`define DDTP_T2_RTP_LO        5
`define DDTP_T2_CKE_HI        4
`define DDTP_T2_CKE_LO        0
`define DDTP_T2_RESET         32'h4532a722
`define DDTP_T2_WMASK         32'h7fffffff

// config_reg_two fields
`define DDTP_C2_PARTIAL_REFRESH_SELECT_HI       18
`define DDTP_C2_PARTIAL_REFRESH_SELECT_LO       16
`define DDTP_C2_ROW_HI        2
`define DDTP_C2_ROW_LO        0
`define DDTP_C2_RESET         32'h00000000
`define DDTP_C2_WMASK         32'h00070007
`define DDTP_ROW_BITS_BASE    5'h09
`define DDTP_ROW_BITS_DEFAULT 5'h10

// command codes from the scheduler
`define DDTP_CMD_NOP          3'h0
`define DDTP_CMD_ACTIVATE     3'h1
`define DDTP_CMD_READ         3'h2
`define DDTP_CMD_WRITE        3'h3
`define DDTP_CMD_PRECHARGE    3'h4
`define DDTP_CMD_REFRESH      3'h5
`define DDTP_CMD_LOAD_MODE    3'h6

`define DDTP_NUM_BANKS        8
`define DDTP_GAP_W            8

`endif

// File: ddtp_gap_timer.v
// minimum-spacing down counter for one timing constraint
// assumes start_i is a one-cycle pulse on the same clock
`timescale 1ns/100ps
`include "ddtp_defines.vh"

module ddtp_gap_timer (
  input  wire                    clk_i,
  input  wire                    rstn_i,
  input  wire                    start_i,
  input  wire [`DDTP_GAP_W-1:0]  value_i,
  output wire                    ok_o
);

  reg [`DDTP_GAP_W-1:0] cnt_reg;   // cycles still blocked
  reg [`DDTP_GAP_W-1:0] cnt_next;

  // reload on trigger, else count down to zero
  always @* begin
    cnt_next = cnt_reg;
    if (start_i) begin
      cnt_next = value_i;
    end else if (cnt_reg != {`DDTP_GAP_W{1'b0}}) begin
      cnt_next = cnt_reg - 8'h01;
    end
  end

  always @(posedge clk_i) begin
    if (!rstn_i) begin
      cnt_reg <= {`DDTP_GAP_W{1'b0}};
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // value cycles blocked after the reload edge, giving value+1 spacing;
  // no start_i term: the triggers come from ok_o and would close a comb loop
  assign ok_o = (cnt_reg == {`DDTP_GAP_W{1'b0}});

endmodule

// File: ddtp_row_guard.v
// per-bank watch on how many refresh intervals a row stays open
// assumes activate/precharge strobes and refresh ticks on the same clock
`timescale 1ns/100ps
`include "ddtp_defines.vh"

module ddtp_row_guard (
  input  wire                       clk_i,
  input  wire                       rstn_i,
  input  wire [`DDTP_NUM_BANKS-1:0] act_i,
  input  wire [`DDTP_NUM_BANKS-1:0] pre_i,
  input  wire                       refresh_tick_i,
  input  wire [3:0]                 max_open_row_intervals_i,
  output wire [`DDTP_NUM_BANKS-1:0] open_o,
  output wire [`DDTP_NUM_BANKS-1:0] force_pre_o
);

  genvar b;
  generate
    for (b = 0; b < `DDTP_NUM_BANKS; b = b + 1) begin : g_bank
      reg       open_reg;   // bank holds an open row
      reg [4:0] ivl_reg;    // refresh intervals seen since activate

      // precharge closes, activate restarts the interval count
      always @(posedge clk_i) begin
        if (!rstn_i) begin
          open_reg <= 1'b0;
          ivl_reg  <= 5'h00;
        end else if (act_i[b]) begin
          open_reg <= 1'b1;
          ivl_reg  <= 5'h00;
        end else if (pre_i[b]) begin
          open_reg <= 1'b0;
        end else if (open_reg && refresh_tick_i && ivl_reg != 5'h1f) begin
          ivl_reg <= ivl_reg + 5'h01;
        end
      end

      assign open_o[b] = open_reg;
      // close once programmed+1 intervals have elapsed
      assign force_pre_o[b] = open_reg && (ivl_reg >= ({1'b0, max_open_row_intervals_i} + 5'h01));
    end
  endgenerate

endmodule

// File: ddtp_top_asserts.sv
// port checker for the second timing set block
// watches top ports only; shadows the apb registers itself
`timescale 1ns/100ps
`include "ddtp_defines.vh"
module ddtp_top_asserts (
  input wire logic        clk_i,
  input wire logic        rstn_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        cmd_valid_i,
  input wire logic [2:0]  cmd_code_i,
  input wire logic [2:0]  cmd_bank_i,
  input wire logic        cmd_ready_o,
  input wire logic        cmd_issue_o,
  input wire logic [2:0]  cmd_code_o,
  input wire logic [2:0]  cmd_bank_o,
  input wire logic        pd_req_i,
  input wire logic        sr_req_i,
  input wire logic        mem_cke_o,
  input wire logic        refresh_tick_i,
  input wire logic [7:0]  force_pre_o,
  input wire logic [2:0]  partial_refresh_select_o,
  input wire logic [4:0]  row_addr_bits_o,
  input wire logic        init_start_o
);
  logic [31:0] main_q, t2_q, c2_q; // register shadows
  logic [7:0]  hc, rc;             // level age, cycles since read
  logic        cke_q;              // last sampled clock enable
  wire         wr  = psel_i & penable_i & pwrite_i & pready_o;
  wire         acc = cmd_valid_i & cmd_ready_o;
  // shadows and counters; counters saturate so reset looks long ago
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      main_q <= `DDTP_MAIN_RESET;
      t2_q <= `DDTP_T2_RESET;
      c2_q <= `DDTP_C2_RESET;
      hc <= 8'hff;
      rc <= 8'hff;
      cke_q <= 1'b1;
    end else begin
      if (wr && paddr_i == 12'h000) main_q <= pwdata_i & 32'h00000003;
      if (wr && paddr_i == 12'h004 && main_q[0]) t2_q <= pwdata_i & `DDTP_T2_WMASK;
      if (wr && paddr_i == 12'h008) c2_q <= pwdata_i & `DDTP_C2_WMASK;
      cke_q <= mem_cke_o;
      hc <= (mem_cke_o != cke_q) ? 8'h01 : hc + {7'h0, hc != 8'hff};
      rc <= (acc && cmd_code_i == `DDTP_CMD_READ) ? 8'h00 : rc + {7'h0, rc != 8'hff};
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  AST_CKE_HOLD: assert property ((mem_cke_o != cke_q) |-> hc >= {3'h0, t2_q[4:0]} + 8'h01)
    else $error("clock enable level too short");
  AST_RTP_GAP: assert property ((acc && cmd_code_i == `DDTP_CMD_PRECHARGE) |-> rc >= {5'h0, t2_q[7:5]})
    else $error("precharge too soon after read");
  AST_ISSUE: assert property (acc |=> cmd_issue_o && cmd_code_o == $past(cmd_code_i))
    else $error("accepted command not issued");
  AST_CKE_BLOCK: assert property (!mem_cke_o |-> !cmd_ready_o)
    else $error("command accepted with clock disabled");
  AST_RSVD_ZERO: assert property ((psel_i && penable_i && !pwrite_i && paddr_i == 12'h004) |-> !prdata_o[31])
    else $error("reserved timing bit reads one");
  AST_INIT: assert property ((wr && paddr_i == 12'h008) |=> init_start_o)
    else $error("config two write without init start");
  AST_ROWS: assert property (row_addr_bits_o == (main_q[1] ? {2'h0, c2_q[2:0]} + 5'h09 : 5'h10))
    else $error("row address width wrong");
  AST_PARTIAL_REFRESH_SELECT: assert property (partial_refresh_select_o == (main_q[1] ? c2_q[18:16] : 3'h0))
    else $error("partial refresh select wrong");
  COV_RTP: cover property (acc && cmd_code_i == `DDTP_CMD_PRECHARGE && rc != 8'hff);
  COV_CKE: cover property ($fell(mem_cke_o));
  COV_INIT: cover property (init_start_o);
endmodule
bind ddtp_top ddtp_top_asserts u_chk (.clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i), .cmd_bank_i(cmd_bank_i),
  .cmd_ready_o(cmd_ready_o), .cmd_issue_o(cmd_issue_o), .cmd_code_o(cmd_code_o), .cmd_bank_o(cmd_bank_o),
  .pd_req_i(pd_req_i), .sr_req_i(sr_req_i), .mem_cke_o(mem_cke_o), .refresh_tick_i(refresh_tick_i),
  .force_pre_o(force_pre_o), .partial_refresh_select_o(partial_refresh_select_o),
  .row_addr_bits_o(row_addr_bits_o), .init_start_o(init_start_o));

// File: ddtp_sdram_model.sv
// behavioural sdram on the far side of the command port
// assumes issued commands are one-cycle pulses on clk_i
`timescale 1ns/100ps
`include "ddtp_defines.vh"
module ddtp_sdram_model (
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic       issue_i,
  input  wire logic [2:0] code_i,
  input  wire logic [2:0] bank_i,
  input  wire logic       cke_i,
  output logic      [7:0] open_o,
  output logic     [15:0] n_cmd_o,
  output logic            err_o
);
  // bank state and command tally
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      open_o <= 8'h00;
      n_cmd_o <= 16'h0000;
      err_o <= 1'b0;
    end else if (issue_i) begin
      n_cmd_o <= n_cmd_o + 16'h0001;
      if (!cke_i) err_o <= 1'b1; // a disabled clock ignores commands
      if (code_i == `DDTP_CMD_ACTIVATE) open_o[bank_i] <= 1'b1;
      if (code_i == `DDTP_CMD_PRECHARGE) open_o[bank_i] <= 1'b0;
    end
  end
endmodule

// File: ddtp_top_tb.sv
// self-checking bench for the timing set two block
// drives apb, commands and power requests; sdram model on the far side
`timescale 1ns/100ps
`include "ddtp_defines.vh"
module ddtp_top_tb;
  logic clk_i = 0, rstn_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic [11:0] paddr_i = 0;
  logic [31:0] pwdata_i = 0, rd;
  logic cmd_valid_i = 0, pd_req_i = 0, sr_req_i = 0, refresh_tick_i = 0, er;
  logic [2:0] cmd_code_i = 0, cmd_bank_i = 0;
  wire [31:0] prdata_o;
  wire pready_o, pslverr_o, cmd_ready_o, cmd_issue_o, mem_cke_o, init_start_o, m_err;
  wire [2:0] cmd_code_o, cmd_bank_o, partial_refresh_select_o;
  wire [4:0] row_addr_bits_o;
  wire [7:0] force_pre_o, m_open;
  wire [15:0] m_cnt;
  int n_fail = 0, tests_run = 0, n;
  // rows: write flag, address, write data, expected read back
  localparam logic [76:0] ROWS [11] = '{
    {1'b0, 12'h000, 32'h0, 32'h00000000}, {1'b0, 12'h004, 32'h0, 32'h4532a722},
    {1'b0, 12'h008, 32'h0, 32'h00000000}, {1'b1, 12'h004, 32'hffffffff, 32'h4532a722},
    {1'b1, 12'h000, 32'h00000001, 32'h00000001}, {1'b1, 12'h004, 32'hffffffff, 32'h7fffffff},
    {1'b1, 12'h008, 32'hffffffff, 32'h00070007}, {1'b1, 12'h008, 32'h00050002, 32'h00050002},
    {1'b1, 12'h00c, 32'hffffffff, 32'h00000003},
    {1'b1, 12'h010, 32'h00000005, 32'h00000000}, {1'b1, 12'h004, 32'h0e040662, 32'h0e040662}};
  always #50 clk_i = ~clk_i;
  ddtp_top DUT (.clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i), .cmd_bank_i(cmd_bank_i), .cmd_ready_o(cmd_ready_o),
    .cmd_issue_o(cmd_issue_o), .cmd_code_o(cmd_code_o), .cmd_bank_o(cmd_bank_o), .pd_req_i(pd_req_i),
    .sr_req_i(sr_req_i), .mem_cke_o(mem_cke_o), .refresh_tick_i(refresh_tick_i), .force_pre_o(force_pre_o),
    .partial_refresh_select_o(partial_refresh_select_o), .row_addr_bits_o(row_addr_bits_o),
    .init_start_o(init_start_o));
  ddtp_sdram_model u_mem (.clk_i(clk_i), .rstn_i(rstn_i), .issue_i(cmd_issue_o), .code_i(cmd_code_o),
    .bank_i(cmd_bank_o), .cke_i(mem_cke_o), .open_o(m_open), .n_cmd_o(m_cnt), .err_o(m_err));
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one edge of a bounded wait; running out ends the run
  task automatic step(inout int k);
    @(posedge clk_i);
    k++;
    if (k > 400) begin
      n_fail++;
      end_of_test();
    end
  endtask
  // apb transfer: idle edge, setup, access until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k = 0;
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do step(k); while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  // hold a command request until taken; n counts refused edges
  task automatic cmd(input logic [2:0] c);
    logic r;
    n = 0;
    cmd_valid_i <= 1'b1;
    cmd_code_i <= c;
    cmd_bank_i <= 3'h2;
    // ready is read at the falling edge, settled for the edge that follows
    do begin
      @(negedge clk_i);
      r = cmd_ready_o;
      step(n);
    end while (r !== 1'b1);
    n--;
  endtask
  task automatic idle;
    cmd_valid_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // enter power-down or self-refresh, then leave; returns one edge after the exit edge
  task automatic lp(input logic sr);
    int k = 0;
    logic r;
    if (sr) sr_req_i <= 1'b1;
    else pd_req_i <= 1'b1;
    // clock enable is read at the falling edge, where it has settled
    do begin
      @(negedge clk_i);
      r = mem_cke_o;
      step(k);
    end while (r !== 1'b0);
    sr_req_i <= 1'b0;
    pd_req_i <= 1'b0;
    do begin
      @(negedge clk_i);
      r = mem_cke_o;
      step(k);
    end while (r !== 1'b1);
  endtask
  task automatic tick;
    refresh_tick_i <= 1'b1;
    @(posedge clk_i);
    refresh_tick_i <= 1'b0;
    @(posedge clk_i);
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    rstn_i <= 1'b1;
    // last row: exit field is the larger delay minus one, termination lead 0
    foreach (ROWS[i]) begin
      if (ROWS[i][76]) apb(1'b1, ROWS[i][75:64], ROWS[i][63:32]);
      apb(1'b0, ROWS[i][75:64], 32'h0);
      chk("prdata", ROWS[i][31:0], rd);
      chk("pslverr", 32'(ROWS[i][75:64] == 12'h010), 32'(er));
    end
    $display("register table done");
    chk("rows off", 32'h10, 32'(row_addr_bits_o));
    chk("partial_refresh_select off", 32'h0, 32'(partial_refresh_select_o));
    apb(1'b1, 12'h000, 32'h00000003);
    @(posedge clk_i);
    chk("rows on", 32'h0b, 32'(row_addr_bits_o));
    chk("partial_refresh_select on", 32'h5, 32'(partial_refresh_select_o));
    apb(1'b1, 12'h008, 32'h00060003);
    @(negedge clk_i);
    chk("init pulse", 32'h1, 32'(init_start_o));
    chk("rows new", 32'h0c, 32'(row_addr_bits_o));
    chk("partial_refresh_select new", 32'h6, 32'(partial_refresh_select_o));
    @(negedge clk_i);
    chk("init end", 32'h0, 32'(init_start_o));
    @(posedge clk_i);
    $display("addressing done");
    cmd(`DDTP_CMD_READ);
    cmd(`DDTP_CMD_PRECHARGE);
    chk("rtp wait", 32'h3, 32'(n));
    idle();
    lp(1'b0);
    cmd(`DDTP_CMD_WRITE);
    chk("pd exit wait", 32'h2, 32'(n));
    idle();
    lp(1'b1);
    cmd(`DDTP_CMD_READ);
    chk("sr read wait", 32'h5, 32'(n));
    idle();
    lp(1'b1);
    cmd(`DDTP_CMD_WRITE);
    chk("sr write wait", 32'h3, 32'(n));
    idle();
    $display("spacing done");
    cmd(`DDTP_CMD_ACTIVATE);
    idle();
    tick();
    chk("force one", 32'h0, 32'(force_pre_o));
    tick();
    chk("force two", 32'h04, 32'(force_pre_o));
    chk("model open", 32'h04, 32'(m_open));
    cmd(`DDTP_CMD_PRECHARGE);
    idle();
    @(posedge clk_i);
    chk("force clear", 32'h0, 32'(force_pre_o));
    chk("issued", 32'd7, 32'(m_cnt));
    chk("model err", 32'h0, 32'(m_err));
    $display("row guard done");
    rstn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    apb(1'b0, 12'h004, 32'h0);
    chk("reset t2", 32'h4532a722, rd);
    chk("reset cke", 32'h1, 32'(mem_cke_o));
    $display("reset done");
    end_of_test();
  end
endmodule
